// ===== rtl/ext_control_port.sv
// External control I/O port: command inputs, status outputs and APB registers
// How it works
// R1 - A three-way selector picks disabled (inputs ignored, status still driven), enabled, or simulator control.
// R2 - While the remote flag is set every port command is dropped.
// R3 - The general port and simulator control never act together; only the selected mode is live.
// R4 - Memory select 1 and 2 form a 2-bit number, bit 0 and bit 1, naming memories 1 to 4.
// R5 - A falling recall input loads the chosen memory and flags compile for sequence and simulation.
// R6 - Falling edges of off, on, start, stop, hold, branch 1 and branch 2 raise their actions.
// R7 - A falling peak-hold clear input clears the peak-hold value.
// R8 - Output, protection, limiter, gain regulation and busy outputs follow a selectable polarity.
// R9 - Power and range outputs have fixed polarity: power high when on, range high for 100 V.
// R10 - The step sync code appears on two outputs, code 1 as bit 0 and code 2 as bit 1.
// R11 - The trigger pulse has a selectable polarity and width.
// R12 - With loopback in enabled or disabled mode, sync bit 0 goes to status out and bit 1 to quick sync out.
// R13 - In simulator control the quick-change sync and a test sync on status out are driven.
// R14 - The attached simulator must be powered only after this unit is in simulator control.
// R15 - The operator should leave the selector disabled while the port is unused.
// R16 - Each input is synchronised and filtered before edge detection, one action per falling edge.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ext_control_port
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Port command inputs, active low; memory selects, active high
    input wire logic [ctl_port_pkg::N_CMD-1:0] i_cmd_n,
    input wire logic i_mem_sel1,
    input wire logic i_mem_sel2,
    // Port status outputs
    output logic o_power,
    output logic o_out_state,
    output logic o_protect,
    output logic o_limiter,
    output logic o_gain_reg,
    output logic o_busy,
    output logic o_range,
    output logic o_sync_code1,
    output logic o_sync_code2,
    output logic o_trigger,
    // Loopback connectors
    output logic o_status_conn,
    output logic o_qc_sync_conn,
    // Interrupt
    output logic o_irq
);
    logic [ctl_port_pkg::CTRL_W-1:0] ctrl_r;
    logic [ctl_port_pkg::ST_W-1:0] state_r;
    logic [ctl_port_pkg::TRIG_W-1:0] trig_width_r;
    logic [ctl_port_pkg::N_CMD-1:0] irq_stat_r;
    logic [ctl_port_pkg::N_CMD-1:0] irq_mask_r;
    logic [ctl_port_pkg::N_CMD-1:0] level;
    logic [ctl_port_pkg::N_CMD-1:0] level_d_r;
    logic [ctl_port_pkg::N_CMD-1:0] fall;
    logic [ctl_port_pkg::N_CMD-1:0] cmd_evt;
    logic [1:0] mem_num_r;
    logic [1:0] mem_num_nxt;
    logic sel1_lvl;
    logic sel2_lvl;
    logic port_live;
    logic sim_mode;
    logic pol_pos;
    logic trig_active;
    logic trig_fire_r;
    logic wr;
    logic rd;
    logic addr_ok;
    ctl_port_pkg::ext_sel_t sel;

    function automatic logic polar(input logic active, input logic positive);
        polar = positive ? active : ~active;
    endfunction

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign addr_ok = (i_paddr == ctl_port_pkg::ADDR_CTRL) || (i_paddr == ctl_port_pkg::ADDR_STATE)
        || (i_paddr == ctl_port_pkg::ADDR_TRIG) || (i_paddr == ctl_port_pkg::ADDR_IRQ_STAT)
        || (i_paddr == ctl_port_pkg::ADDR_IRQ_MASK) || (i_paddr == ctl_port_pkg::ADDR_PINS);
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // Illegal selector code falls back to disabled
    always_comb
    begin
        unique case (ctrl_r[ctl_port_pkg::CTRL_SEL_LSB +: 2])
            2'h1: sel = ctl_port_pkg::SEL_ENABLE;
            2'h2: sel = ctl_port_pkg::SEL_SIM_CTRL;
            default: sel = ctl_port_pkg::SEL_DISABLE;
        endcase
    end

    assign port_live = (sel == ctl_port_pkg::SEL_ENABLE)
        && !ctrl_r[ctl_port_pkg::CTRL_REMOTE_BIT]; // R1 R2 R3
    assign sim_mode = (sel == ctl_port_pkg::SEL_SIM_CTRL); // R3
    assign pol_pos = ctrl_r[ctl_port_pkg::CTRL_POL_BIT];

    genvar g;
    generate
        for (g = 0; g < ctl_port_pkg::N_CMD; g++)
        begin : g_cmd
            input_filter u_filt
            (
                .i_ref_clk(i_ref_clk),
                .i_reset(i_reset),
                .i_pin(i_cmd_n[g]),
                .o_level(level[g])
            ); // R16
        end
    endgenerate

    input_filter u_sel1
    (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_pin(i_mem_sel1),
        .o_level(sel1_lvl)
    );

    input_filter u_sel2
    (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_pin(i_mem_sel2),
        .o_level(sel2_lvl)
    );

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            level_d_r <= '1;
        else
            level_d_r <= level;
    end

    assign fall = level_d_r & ~level; // R16
    assign cmd_evt = port_live ? fall : '0; // R1 R2 R6 R7
    assign mem_num_nxt = {sel2_lvl, sel1_lvl}; // R4

    // Memory number latched with the recall edge
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            mem_num_r <= 2'h0;
        else if (cmd_evt[ctl_port_pkg::CMD_RECALL])
            mem_num_r <= mem_num_nxt; // R4 R5
    end

    // Sticky command events; the set wins over a write-one clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            irq_stat_r <= '0;
        else if (wr && i_paddr == ctl_port_pkg::ADDR_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~i_pwdata[ctl_port_pkg::N_CMD-1:0]) | cmd_evt; // R5 R6 R7
        else
            irq_stat_r <= irq_stat_r | cmd_evt; // R5 R6 R7
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            irq_mask_r <= '0;
        else if (wr && i_paddr == ctl_port_pkg::ADDR_IRQ_MASK)
            irq_mask_r <= i_pwdata[ctl_port_pkg::N_CMD-1:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            ctrl_r <= ctl_port_pkg::CTRL_RESET;
        else if (wr && i_paddr == ctl_port_pkg::ADDR_CTRL)
            ctrl_r <= i_pwdata[ctl_port_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            state_r <= ctl_port_pkg::ST_RESET;
        else if (wr && i_paddr == ctl_port_pkg::ADDR_STATE)
            state_r <= i_pwdata[ctl_port_pkg::ST_W-1:0];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            trig_width_r <= ctl_port_pkg::TRIG_WIDTH_RESET;
        else if (wr && i_paddr == ctl_port_pkg::ADDR_TRIG)
            trig_width_r <= i_pwdata[ctl_port_pkg::TRIG_W-1:0];
    end

    // Software fires the trigger by writing the go bit of STATE
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            trig_fire_r <= 1'b0;
        else
            trig_fire_r <= wr && (i_paddr == ctl_port_pkg::ADDR_STATE)
                && i_pwdata[ctl_port_pkg::ST_TRIG_GO];
    end

    trigger_pulse u_trig
    (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_fire(trig_fire_r),
        .i_width(trig_width_r),
        .o_active(trig_active)
    );

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            o_prdata <= '0;
        else if (i_psel && !i_penable && !i_pwrite)
        begin
            unique case (i_paddr)
                ctl_port_pkg::ADDR_CTRL: o_prdata <= 32'(ctrl_r);
                ctl_port_pkg::ADDR_STATE: o_prdata <= 32'(state_r);
                ctl_port_pkg::ADDR_TRIG: o_prdata <= 32'(trig_width_r);
                ctl_port_pkg::ADDR_IRQ_STAT: o_prdata <= 32'(irq_stat_r);
                ctl_port_pkg::ADDR_IRQ_MASK: o_prdata <= 32'(irq_mask_r);
                ctl_port_pkg::ADDR_PINS: o_prdata <= 32'({mem_num_r, level});
                default: o_prdata <= '0;
            endcase
        end
    end

    // Status pins, registered; driven in every selector setting
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_out_state <= 1'b1;
            o_protect <= 1'b1;
            o_limiter <= 1'b1;
            o_gain_reg <= 1'b1;
            o_busy <= 1'b1;
            o_power <= 1'b0;
            o_range <= 1'b0;
            o_sync_code1 <= 1'b0;
            o_sync_code2 <= 1'b0;
            o_trigger <= 1'b1;
        end
        else
        begin
            o_out_state <= polar(state_r[ctl_port_pkg::ST_OUT_ON], pol_pos); // R8
            o_protect <= polar(state_r[ctl_port_pkg::ST_PROT], pol_pos); // R8
            o_limiter <= polar(state_r[ctl_port_pkg::ST_LIMIT], pol_pos); // R8
            o_gain_reg <= polar(state_r[ctl_port_pkg::ST_AGC], pol_pos); // R8
            o_busy <= polar(state_r[ctl_port_pkg::ST_BUSY], pol_pos); // R8
            o_power <= state_r[ctl_port_pkg::ST_POWER]; // R9
            o_range <= state_r[ctl_port_pkg::ST_RANGE_100]; // R9
            o_sync_code1 <= state_r[ctl_port_pkg::ST_SYNC_LSB]; // R10
            o_sync_code2 <= state_r[ctl_port_pkg::ST_SYNC_LSB + 1]; // R10
            o_trigger <= polar(trig_active, ctrl_r[ctl_port_pkg::CTRL_TPOL_BIT]); // R11
        end
    end

    // Loopback and simulator connectors
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_status_conn <= 1'b0;
            o_qc_sync_conn <= 1'b0;
        end
        else if (sim_mode)
        begin
            o_status_conn <= state_r[ctl_port_pkg::ST_TEST_SYNC]; // R13
            o_qc_sync_conn <= state_r[ctl_port_pkg::ST_QC_SYNC]; // R13
        end
        else if (ctrl_r[ctl_port_pkg::CTRL_LOOP_BIT])
        begin
            o_status_conn <= state_r[ctl_port_pkg::ST_SYNC_LSB]; // R12
            o_qc_sync_conn <= state_r[ctl_port_pkg::ST_SYNC_LSB + 1]; // R12
        end
        else
        begin
            o_status_conn <= 1'b0;
            o_qc_sync_conn <= 1'b0;
        end
    end

    ignored_when_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
        !port_live && !wr |=> $stable(irq_stat_r))
        else $error("command passed while port not live");

    remote_block_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
        ctrl_r[ctl_port_pkg::CTRL_REMOTE_BIT] && !wr |=> $stable(irq_stat_r))
        else $error("event recorded under remote control");

    mode_exclusive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R3
        sim_mode && !wr |=> $stable(irq_stat_r)
        && o_status_conn == $past(state_r[ctl_port_pkg::ST_TEST_SYNC]))
        else $error("both modes active");

    mem_number_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R4 R5
        cmd_evt[ctl_port_pkg::CMD_RECALL] |=> mem_num_r == $past(mem_num_nxt))
        else $error("memory number not latched");

    single_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R16
        fall[ctl_port_pkg::CMD_OUT_ON] |=> !fall[ctl_port_pkg::CMD_OUT_ON])
        else $error("double action from one edge");

    event_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R6 R7
        cmd_evt[ctl_port_pkg::CMD_PEAK_CLR] |=> irq_stat_r[ctl_port_pkg::CMD_PEAK_CLR])
        else $error("event flag not set");

    status_polarity_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R8
        ##1 o_busy == ($past(state_r[ctl_port_pkg::ST_BUSY]) ~^ $past(pol_pos)))
        else $error("busy polarity wrong");

    fixed_polarity_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R9
        ##1 o_range == $past(state_r[ctl_port_pkg::ST_RANGE_100]))
        else $error("range output wrong");

    sync_code_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
        ##1 {o_sync_code2, o_sync_code1} == $past(state_r[ctl_port_pkg::ST_SYNC_LSB +: 2]))
        else $error("sync code wrong");

    trig_start_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R11
        trig_fire_r && !trig_active |=> ##1 o_trigger == ctrl_r[ctl_port_pkg::CTRL_TPOL_BIT])
        else $error("trigger pulse missing");

    loopback_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
        !sim_mode && ctrl_r[ctl_port_pkg::CTRL_LOOP_BIT] && $stable(state_r)
        |=> o_qc_sync_conn == o_sync_code2)
        else $error("loopback bit 1 wrong");

    sim_sync_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
        sim_mode |=> o_qc_sync_conn == $past(state_r[ctl_port_pkg::ST_QC_SYNC]))
        else $error("quick sync not driven");
endmodule

// ===== include/ctl_port_pkg.sv
// Constants and types shared by the external control port design
package ctl_port_pkg;
    // Selector settings
    typedef enum logic [1:0] {SEL_DISABLE, SEL_ENABLE, SEL_SIM_CTRL} ext_sel_t;

    // Falling-edge command inputs
    localparam int N_CMD = 9;
    localparam int CMD_OUT_OFF = 0;
    localparam int CMD_OUT_ON = 1;
    localparam int CMD_SEQ_START = 2;
    localparam int CMD_SEQ_STOP = 3;
    localparam int CMD_SEQ_HOLD = 4;
    localparam int CMD_BRANCH1 = 5;
    localparam int CMD_BRANCH2 = 6;
    localparam int CMD_RECALL = 7;
    localparam int CMD_PEAK_CLR = 8;

    // Input filter: input must hold steady this long
    localparam int FILTER_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_W = $clog2(FILTER_CYCLES + 1);

    // Trigger pulse width counter, in clock cycles
    localparam int TRIG_W = 16;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_PINS = 8'h14;

    // CTRL fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_TPOL_BIT = 3;
    localparam int CTRL_REMOTE_BIT = 4;
    localparam int CTRL_LOOP_BIT = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // STATE fields (software-driven instrument state)
    localparam int ST_OUT_ON = 0;
    localparam int ST_PROT = 1;
    localparam int ST_LIMIT = 2;
    localparam int ST_AGC = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_POWER = 5;
    localparam int ST_RANGE_100 = 6;
    localparam int ST_SYNC_LSB = 7;
    localparam int ST_QC_SYNC = 9;
    localparam int ST_TEST_SYNC = 10;
    localparam int ST_TRIG_GO = 11;
    localparam int ST_W = 11;
    localparam logic [ST_W-1:0] ST_RESET = 11'h000;

    localparam logic [TRIG_W-1:0] TRIG_WIDTH_RESET = 16'h0032;
endpackage

// ===== rtl/input_filter.sv
// Synchroniser and steady-level filter for one control input
`timescale 1ns/1ps
module input_filter
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Raw pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    logic meta_r;
    logic sync_r;
    logic [ctl_port_pkg::FILTER_W-1:0] cnt_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end
        else
        begin
            meta_r <= i_pin;
            sync_r <= meta_r;
        end
    end

    // Level only follows after it has stayed put for the whole filter time
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            cnt_r <= '0;
            o_level <= 1'b1;
        end
        else if (sync_r == o_level)
            cnt_r <= '0;
        else if (cnt_r == ctl_port_pkg::FILTER_W'(ctl_port_pkg::FILTER_CYCLES - 1))
        begin
            cnt_r <= '0;
            o_level <= sync_r;
        end
        else
            cnt_r <= cnt_r + 1'b1;
    end
endmodule

// ===== rtl/trigger_pulse.sv
// Trigger output pulse generator with programmable width
`timescale 1ns/1ps
module trigger_pulse
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Request and settings
    input wire logic i_fire,
    input wire logic [ctl_port_pkg::TRIG_W-1:0] i_width,
    // Pulse active high
    output logic o_active
);
    logic [ctl_port_pkg::TRIG_W-1:0] cnt_r;

    // A new request while a pulse runs is ignored; width zero is taken as one cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            cnt_r <= '0;
            o_active <= 1'b0;
        end
        else if (!o_active && i_fire)
        begin
            o_active <= 1'b1;
            cnt_r <= (i_width == '0) ? ctl_port_pkg::TRIG_W'(1) : i_width;
        end
        else if (o_active)
        begin
            if (cnt_r == ctl_port_pkg::TRIG_W'(1))
                o_active <= 1'b0;
            cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

// ===== testbench/ctl_partner.sv
// External controller model that drives the command and memory-select pins
`timescale 1ns/1ps
module ctl_partner
(
    // Clock
    input wire logic i_ref_clk,
    // Request from the bench
    input wire logic i_go,
    input wire logic [3:0] i_idx,
    input wire logic [7:0] i_low,
    input wire logic [1:0] i_mem,
    // Port pins
    output logic [ctl_port_pkg::N_CMD-1:0] o_cmd_n,
    output logic o_mem_sel1,
    output logic o_mem_sel2,
    output logic o_busy
);
    localparam int REST_CYCLES = 60;
    logic [7:0] cnt_r;
    logic low_r;

    initial
    begin
        o_cmd_n = '1;
        o_mem_sel1 = 1'b0;
        o_mem_sel2 = 1'b0;
        o_busy = 1'b0;
        low_r = 1'b0;
        cnt_r = 8'h00;
    end

    // One falling edge per request, then a steady high rest
    always @(posedge i_ref_clk)
    begin
        if (i_go)
        begin
            o_busy <= 1'b1;
            low_r <= 1'b1;
            cnt_r <= i_low;
            o_mem_sel1 <= i_mem[0];
            o_mem_sel2 <= i_mem[1];
            o_cmd_n[i_idx] <= 1'b0;
        end
        else if (o_busy)
        begin
            if (cnt_r > 8'h01)
                cnt_r <= cnt_r - 8'h01;
            else if (low_r)
            begin
                low_r <= 1'b0;
                cnt_r <= 8'(REST_CYCLES);
                o_cmd_n <= '1;
            end
            else
                o_busy <= 1'b0;
        end
    end
endmodule

// ===== testbench/external_control_io_port_tb_top.sv
// Self-checking bench for the external control port
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: mismatch got %0h exp %0h", $time, got, exp); end end
module external_control_io_port_tb_top;
    typedef struct packed {logic [5:0] ctrl; logic [11:0] state; logic [10:0] pins;} row_t;
    localparam int LIMIT = 20000;
    logic i_ref_clk, i_reset, psel, penable, pwrite, pready, pslverr, ms1, ms2, go, p_busy, err;
    logic o_power, o_out_state, o_protect, o_limiter, o_gain_reg, o_busy, o_range;
    logic o_sync_code1, o_sync_code2, o_trigger, o_status_conn, o_qc_sync_conn, o_irq;
    logic [7:0] paddr, low;
    logic [31:0] pwdata, prdata, rd;
    logic [ctl_port_pkg::N_CMD-1:0] cmd_n;
    logic [3:0] idx;
    logic [1:0] mem;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int cnt;
    row_t rows [8] = '{'{6'h00, 12'h01f, 11'h000}, '{6'h04, 12'h01f, 11'h3e0},
        '{6'h04, 12'h060, 11'h410}, '{6'h21, 12'h080, 11'h3ea}, '{6'h20, 12'h100, 11'h3e5},
        '{6'h02, 12'h600, 11'h3e3}, '{6'h22, 12'h180, 11'h3ec}, '{6'h01, 12'h180, 11'h3ec}};
    logic [7:0] modes [4] = '{8'h00, 8'h11, 8'h02, 8'h03};

    ext_control_port u_ext_control_port (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_cmd_n(cmd_n), .i_mem_sel1(ms1), .i_mem_sel2(ms2), .o_power(o_power),
        .o_out_state(o_out_state), .o_protect(o_protect), .o_limiter(o_limiter),
        .o_gain_reg(o_gain_reg), .o_busy(o_busy), .o_range(o_range),
        .o_sync_code1(o_sync_code1), .o_sync_code2(o_sync_code2), .o_trigger(o_trigger),
        .o_status_conn(o_status_conn), .o_qc_sync_conn(o_qc_sync_conn), .o_irq(o_irq));
    ctl_partner u_ctl_partner (.i_ref_clk(i_ref_clk), .i_go(go), .i_idx(idx), .i_low(low),
        .i_mem(mem), .o_cmd_n(cmd_n), .o_mem_sel1(ms1), .o_mem_sel2(ms2), .o_busy(p_busy));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            end_sim();
        end
    end

    function automatic logic [10:0] pins();
        return {o_power, o_out_state, o_protect, o_limiter, o_gain_reg, o_busy, o_range,
            o_sync_code1, o_sync_code2, o_status_conn, o_qc_sync_conn};
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        do @(posedge i_ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // Falling edge on one pin, held low for the given count
    task automatic pulse(input logic [3:0] i, input logic [7:0] l, input logic [1:0] m);
        go <= 1'b1;
        idx <= i;
        low <= l;
        mem <= m;
        @(posedge i_ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        while (p_busy !== 1'b0) @(posedge i_ref_clk);
    endtask

    task automatic end_sim();
        $display("Counts: %0d errors in %0d checks", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        i_reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        go = 1'b0;
        idx = 4'h0;
        low = 8'h00;
        mem = 2'h0;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        `CHK(pins(), 11'h3e0)
        `CHK(o_trigger, 1'b1)
        `CHK(o_irq, 1'b0)
        apb(1'b0, ctl_port_pkg::ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, ctl_port_pkg::ADDR_TRIG, 32'h0);
        `CHK(rd, 32'h32)
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        // Selector, polarity and sync routing table
        foreach (rows[r])
        begin
            apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'(rows[r].ctrl));
            apb(1'b1, ctl_port_pkg::ADDR_STATE, 32'(rows[r].state));
            repeat (2) @(posedge i_ref_clk);
            `CHK(pins(), rows[r].pins)
        end
        apb(1'b1, ctl_port_pkg::ADDR_STATE, 32'h0);
        apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, ctl_port_pkg::ADDR_IRQ_MASK, 32'h1ff);
        for (int i = 0; i < ctl_port_pkg::N_CMD; i++)
        begin
            pulse(4'(i), 8'd60, 2'(i) ^ 2'b10);
            apb(1'b0, ctl_port_pkg::ADDR_IRQ_STAT, 32'h0);
            `CHK(rd, 32'h1 << i)
            `CHK(o_irq, 1'b1)
            if (i == ctl_port_pkg::CMD_RECALL)
            begin
                apb(1'b0, ctl_port_pkg::ADDR_PINS, 32'h0);
                `CHK(rd[10:9], 2'b01)
            end
            apb(1'b1, ctl_port_pkg::ADDR_IRQ_STAT, 32'h1 << i);
            apb(1'b0, ctl_port_pkg::ADDR_IRQ_STAT, 32'h0);
            `CHK(rd, 32'h0)
        end
        // A short glitch must not count as an edge
        pulse(4'h0, 8'd20, 2'b00);
        apb(1'b0, ctl_port_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h0)
        // Disabled, remote, simulator control and the spare code all drop commands
        foreach (modes[m])
        begin
            apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'(modes[m]));
            pulse(4'h1, 8'd60, 2'b00);
            apb(1'b0, ctl_port_pkg::ADDR_IRQ_STAT, 32'h0);
            `CHK(rd, 32'h0)
        end
        apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, ctl_port_pkg::ADDR_IRQ_MASK, 32'h0);
        pulse(4'h1, 8'd60, 2'b00);
        apb(1'b0, ctl_port_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h2)
        `CHK(o_irq, 1'b0)
        apb(1'b1, ctl_port_pkg::ADDR_IRQ_MASK, 32'h1ff);
        `CHK(o_irq, 1'b1)
        apb(1'b1, ctl_port_pkg::ADDR_IRQ_STAT, 32'h2);
        `CHK(o_irq, 1'b0)
        // Trigger pulse width and polarity
        apb(1'b1, ctl_port_pkg::ADDR_TRIG, 32'h5);
        apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'h9);
        repeat (2) @(posedge i_ref_clk);
        `CHK(o_trigger, 1'b0)
        apb(1'b1, ctl_port_pkg::ADDR_STATE, 32'h800);
        cnt = 0;
        for (int w = 0; w < 20 && o_trigger !== 1'b1; w++) @(posedge i_ref_clk);
        while (o_trigger === 1'b1 && cnt < 50)
        begin
            cnt++;
            @(posedge i_ref_clk);
        end
        `CHK(cnt, 5)
        apb(1'b1, ctl_port_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        `CHK(o_trigger, 1'b1)
        // Second reset in mid-run
        i_reset <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        apb(1'b0, ctl_port_pkg::ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(pins(), 11'h3e0)
        end_sim();
    end
endmodule
